/* File: logic/serial_port_pkg.sv */
package serial_port_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] CONTROL_OFFSET = 8'h14;
	localparam logic [7:0] BUFFER_OFFSET = 8'h18;
	localparam logic [7:0] STATUS_OFFSET = 8'h1C;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h24;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ****************************************************************
	// Control field positions
	// ****************************************************************
	localparam int WRITE_COLLISION_FLAG_POS = 7;
	localparam int ROV_POS = 6;
	localparam int EN_POS = 5;
	localparam int CKP_POS = 4;

	// ****************************************************************
	// Mode codes and divider counts
	// ****************************************************************
	localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
	localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
	localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
	localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;
	// Half periods of the serial clock in system cycles, less one
	localparam logic [4:0] HALF_DIV4 = 5'h01;
	localparam logic [4:0] HALF_DIV16 = 5'h07;
	localparam logic [4:0] HALF_DIV64 = 5'h1F;

	// Interrupt event bits
	localparam int EV_DONE = 0;
	localparam int EV_WRITE_COLLISION_FLAG = 1;
	localparam int EV_ROV = 2;

	// Control register as software sees it
	typedef struct packed {
		logic write_collision_flag;
		logic rov;
		logic enable;
		logic clock_polarity_bit;
		logic [3:0] mode;
	} control_t;

	// Serial pins toward the outside
	typedef struct packed {
		logic sck;
		logic sdo;
	} spi_out_t;

endpackage

/* File: logic/rx_holding_reg.sv */
`timescale 1ns/1ps
// Transfer buffer storage; read data always come from a register
module rx_holding_reg #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] data_in,
	output logic [WIDTH-1:0] data_out
);

	// Load on request only
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			data_out <= '0;
		else if (load_in)
			data_out <= data_in;
	end

endmodule // rx_holding_reg

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// First stage is read only by the second
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= pin_in;
			sync_out <= meta_r;
		end
	end

endmodule // pin_sync

/* File: logic/serial_port_ctrl.sv */
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// How it works
// - New byte with unread buffer flags overflow
// - On overflow keep old byte, drop new
// - Overflow only flagged in slave mode
// - Enable hands clock and data pins to port
// - Control bits read/write, zero after reset
// - Enable cleared returns pins to general use
// - Polarity sets idle level and data edges
// - Modes 0,1,2 are master at osc/4,16,64
// - Buffer full set on byte, cleared on read
module serial_port_ctrl (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic avs_readdatavalid_out,
	// Serial pins
	input wire logic sck_pin_in,
	input wire logic sdi_pin_in,
	input wire logic ss_n_pin_in,
	output serial_port_pkg::spi_out_t spi_out,
	output logic sck_oe_n_out,
	output logic sdo_oe_n_out,
	output logic pins_serial_out,
	output logic irq_out
);
	import serial_port_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	control_t ctrl_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [3:0] bits_r;
	logic busy_r;
	logic full_r;
	logic sck_r;
	logic sck_prev_r;
	logic [4:0] div_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [7:0] buf_q;
	logic [2:0] pins_s;
	logic sck_s, sdi_s, ssn_s;
	logic sck_s_prev_r;

	pin_sync #(.WIDTH(3)) u_sync (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.pin_in({sck_pin_in, sdi_pin_in, ss_n_pin_in}),
		.sync_out(pins_s)
	);
	assign sck_s = pins_s[2];
	assign sdi_s = pins_s[1];
	assign ssn_s = pins_s[0];

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// One wait cycle per access: the answer comes from registers
	wire access = (avs_read_in | avs_write_in) & !ack_r;
	wire wr_go = avs_write_in & !ack_r;
	wire rd_go = avs_read_in & !ack_r;
	wire sel_ctrl = avs_address_in == CONTROL_OFFSET;
	wire sel_buf = avs_address_in == BUFFER_OFFSET;
	wire sel_stat = avs_address_in == STATUS_OFFSET;
	wire sel_istat = avs_address_in == IRQ_STATUS_OFFSET;
	wire sel_imask = avs_address_in == IRQ_MASK_OFFSET;
	wire be0 = avs_byteenable_in[0];
	wire wr_ctrl = wr_go & sel_ctrl & be0;
	wire wr_buf = wr_go & sel_buf & be0;
	wire rd_buf = rd_go & sel_buf;
	wire rd_istat = rd_go & sel_istat;
	control_t wctrl;
	assign wctrl = control_t'(avs_writedata_in[7:0]);

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	wire is_master = (ctrl_r.mode == MODE_MASTER_DIV4) | (ctrl_r.mode == MODE_MASTER_DIV16)
		| (ctrl_r.mode == MODE_MASTER_DIV64);
	wire is_slave = (ctrl_r.mode == MODE_SLAVE_SEL) | (ctrl_r.mode == MODE_SLAVE_NOSEL);
	wire slave_sel = (ctrl_r.mode == MODE_SLAVE_NOSEL) | !ssn_s;
	wire [4:0] half_cnt = (ctrl_r.mode == MODE_MASTER_DIV16) ? HALF_DIV16 :
		(ctrl_r.mode == MODE_MASTER_DIV64) ? HALF_DIV64 : HALF_DIV4;
	wire run = ctrl_r.enable & (is_master | is_slave);

	// Master clock divider: one-cycle enable pulse per half period
	wire half_tick = busy_r & is_master & (div_r == half_cnt);

	// Slave edges seen on the synchronised clock; the active edge leaves idle
	wire s_edge = is_slave & slave_sel & (sck_s != sck_s_prev_r);
	wire s_lead = s_edge & (sck_s != ctrl_r.clock_polarity_bit); // Leaving idle level
	wire s_trail = s_edge & (sck_s == ctrl_r.clock_polarity_bit); // Returning to idle

	// Master drives its own clock: leading edge when it leaves idle
	wire m_lead = half_tick & (sck_r == ctrl_r.clock_polarity_bit);
	wire m_trail = half_tick & (sck_r != ctrl_r.clock_polarity_bit);

	// Receive on the edge back to idle, transmit on the edge leaving idle
	// Polarity clear: receive falling, transmit rising; set: the reverse
	// The first leading edge does not shift, so bit 7 stands for the first sample
	wire samp = m_trail | s_trail;
	wire shft = (m_lead | s_lead) & (bits_r != 4'h0);
	wire byte_done = samp & (bits_r == 4'h7);

	// Overflow: byte ends in slave mode while buffer still unread
	wire ovf = byte_done & full_r & is_slave;
	wire collide = wr_buf & busy_r;
	wire buf_load = byte_done & !full_r;

	rx_holding_reg #(.WIDTH(8)) u_buf (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.load_in(buf_load),
		.data_in({shift_r[6:0], sdi_s}),
		.data_out(buf_q)
	);

	// ****************************************************************
	// Control register
	// ****************************************************************
	// Set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			ctrl_r <= control_t'(CONTROL_RESET);
		else
		begin
			if (wr_ctrl)
				ctrl_r <= wctrl;
			if (collide | (wr_ctrl & wctrl.write_collision_flag))
				ctrl_r.write_collision_flag <= (wr_ctrl & wctrl.write_collision_flag) | collide | (!wr_ctrl & ctrl_r.write_collision_flag);
			if (ovf)
				ctrl_r.rov <= 1'b1;
		end
	end

	// ****************************************************************
	// Shift engine
	// ****************************************************************
	// Disabled port abandons any transfer and empties the buffer
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in || !run)
		begin
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			bits_r <= 4'h0;
			busy_r <= 1'b0;
			full_r <= 1'b0;
			div_r <= 5'h00;
			sck_r <= 1'b0;
		end
		else
		begin
			sck_r <= busy_r & is_master ? (half_tick ? !sck_r : sck_r) : ctrl_r.clock_polarity_bit;
			div_r <= (half_tick | !busy_r) ? 5'h00 : div_r + 5'h01;
			if (wr_buf & !busy_r)
			begin
				tx_r <= avs_writedata_in[7:0];
				busy_r <= is_master;
				bits_r <= 4'h0;
			end
			else if (is_slave & slave_sel & !busy_r & s_edge)
				busy_r <= 1'b1;
			if (shft)
				tx_r <= {tx_r[6:0], 1'b0};
			if (samp)
			begin
				shift_r <= {shift_r[6:0], sdi_s};
				bits_r <= bits_r + 4'h1;
			end
			if (byte_done)
			begin
				bits_r <= 4'h0;
				busy_r <= 1'b0;
			end
			// Read empties, a new byte fills; the fill wins
			if (buf_load)
				full_r <= 1'b1;
			else if (rd_buf)
				full_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Pins and interrupts
	// ****************************************************************
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			spi_out <= '0;
			sck_oe_n_out <= 1'b1;
			sdo_oe_n_out <= 1'b1;
			pins_serial_out <= 1'b0;
			sck_s_prev_r <= 1'b0;
		end
		else
		begin
			sck_s_prev_r <= sck_s;
			pins_serial_out <= ctrl_r.enable;
			spi_out.sck <= sck_r;
			spi_out.sdo <= tx_r[7];
			sck_oe_n_out <= !(ctrl_r.enable & is_master);
			sdo_oe_n_out <= !(ctrl_r.enable & (is_master | slave_sel));
		end
	end

	// Sticky event bits, cleared by a read; an event in that cycle survives
	wire [2:0] events = {ovf, collide, byte_done};
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			irq_stat_r <= 3'h0;
			irq_mask_r <= 3'h0;
			irq_out <= 1'b0;
		end
		else
		begin
			irq_stat_r <= (rd_istat ? 3'h0 : irq_stat_r) | events;
			if (wr_go & sel_imask & be0)
				irq_mask_r <= avs_writedata_in[2:0];
			irq_out <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	wire [31:0] rmux = sel_ctrl ? {24'h0, ctrl_r} : sel_buf ? {24'h0, buf_q} :
		sel_stat ? {30'h0, busy_r, full_r} : sel_istat ? {29'h0, irq_stat_r} :
		sel_imask ? {29'h0, irq_mask_r} : 32'h0;
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			ack_r <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			rdata_r <= 32'h0;
			avs_readdatavalid_out <= 1'b0;
		end
		else
		begin
			ack_r <= access;
			avs_waitrequest_out <= !access; // Low for the one answer cycle
			avs_readdatavalid_out <= rd_go;
			if (rd_go)
				rdata_r <= rmux;
		end
	end
	assign avs_readdata_out = rdata_r;

endmodule // serial_port_ctrl

/* File: dv/serial_port_ctrl_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus and pin checks
// ****************************************************************
module serial_port_ctrl_assertions (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire serial_port_pkg::spi_out_t spi_out,
	input wire logic sck_oe_n_out,
	input wire logic sdo_oe_n_out,
	input wire logic pins_serial_out,
	input wire logic irq_out
);
	import serial_port_pkg::*;
	logic [7:0] ctl_r;
	wire ack = !avs_waitrequest_out;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence ctl_wr;
		avs_write_in && ack && avs_address_in == CONTROL_OFFSET;
	endsequence
	sequence ctl_rd;
		avs_read_in && ack && avs_address_in == CONTROL_OFFSET;
	endsequence
	// Shadow of the last control write, so pin behaviour can be predicted
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			ctl_r <= CONTROL_RESET;
		else if (avs_write_in && ack && avs_address_in == CONTROL_OFFSET)
			ctl_r <= avs_writedata_in[7:0];
	end
	a_wait_single: assert property (ack |=> !ack)
		else $error("acknowledge longer than one cycle");
	a_reset_quiet: assert property ($rose(resetn_in) |-> !irq_out && sck_oe_n_out
		&& sdo_oe_n_out && !pins_serial_out) else $error("outputs active after reset");
	a_ctl_readback: assert property (ctl_rd |-> avs_readdata_out[5:0] == ctl_r[5:0])
		else $error("control readback differs");
	a_upper_zero: assert property (avs_read_in && ack |-> avs_readdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	a_master_no_ovf: assert property (ctl_rd ##0 ctl_r[5] && ctl_r[3:2] == 2'h0
		&& ctl_r[3:0] != 4'h3 && !ctl_r[6] |-> !avs_readdata_out[6])
		else $error("overflow in master mode");
	a_en_pins: assert property (ctl_wr |-> ##2 pins_serial_out == ctl_r[5])
		else $error("pin ownership not following enable");
	a_pins_release: assert property ($fell(pins_serial_out) |-> ##[0:1] sck_oe_n_out
		&& sdo_oe_n_out) else $error("pins still driven after disable");
	a_sck_idle: assert property (ctl_wr ##2 pins_serial_out && ctl_r[3:2] == 2'h0
		&& ctl_r[3:0] != 4'h3 |-> spi_out.sck == ctl_r[4] && !sck_oe_n_out)
		else $error("clock idle level wrong");
	a_div16_half: assert property ($changed(spi_out.sck) && ctl_r[5:0] == 6'h21
		|=> $stable(spi_out.sck)[*7]) else $error("divide by 16 half period short");
endmodule // serial_port_ctrl_assertions

bind serial_port_ctrl serial_port_ctrl_assertions u_chk (.sys_clk_in(sys_clk_in),
	.resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.spi_out(spi_out), .sck_oe_n_out(sck_oe_n_out), .sdo_oe_n_out(sdo_oe_n_out),
	.pins_serial_out(pins_serial_out), .irq_out(irq_out));

/* File: dv/spi_master_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// External SPI master facing the port in slave mode
// ****************************************************************
module spi_master_model (
	input wire logic sys_clk_in,
	output logic sck_out,
	output logic sdo_out,
	output logic ss_n_out
);
	initial
	begin
		sck_out = 1'b0;
		sdo_out = 1'b1;
		ss_n_out = 1'b1;
	end
	// One byte MSB first; clock stands low between frames, as polarity clear expects
	task automatic send(input logic [7:0] b);
		ss_n_out <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			repeat (4) @(posedge sys_clk_in);
			sdo_out <= b[i]; // Data moves with the rising clock edge
			sck_out <= 1'b1;
			repeat (4) @(posedge sys_clk_in);
			sck_out <= 1'b0;
		end
		repeat (4) @(posedge sys_clk_in);
		ss_n_out <= 1'b1;
		sdo_out <= ~sdo_out; // Released line shows no stale bit
		repeat (4) @(posedge sys_clk_in);
	endtask
endmodule // spi_master_model

/* File: dv/sync_serial_port_control_flags_tb.sv */
`timescale 1ns/1ps
module sync_serial_port_control_flags_tb;
	import serial_port_pkg::*;
	logic sys_clk_in, resetn_in, rd, wr, waitreq, sck, sdi, ss_n, sck_oe_n, sdo_oe_n, pins, irq;
	logic rvalid;
	logic [7:0] address, q;
	logic [31:0] writedata, readdata;
	spi_out_t spi;
	int err_count = 0;
	int n_tests = 0;
	// Address, write value, expected readback
	logic [23:0] tbl [6] = '{24'h14FFFF, 24'h145A5A, 24'h140000, 24'h240707, 24'h240000,
		24'h30FF00};
	serial_port_ctrl u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(writedata), .avs_byteenable_in(4'hF), .avs_readdata_out(readdata),
		.avs_waitrequest_out(waitreq), .avs_readdatavalid_out(rvalid), .sck_pin_in(sck),
		.sdi_pin_in(sdi), .ss_n_pin_in(ss_n), .spi_out(spi), .sck_oe_n_out(sck_oe_n),
		.sdo_oe_n_out(sdo_oe_n), .pins_serial_out(pins), .irq_out(irq));
	spi_master_model u_partner (.sys_clk_in(sys_clk_in), .sck_out(sck), .sdo_out(sdi),
		.ss_n_out(ss_n));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task automatic print_verdict();
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge, then releases
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		chk({7'h0, waitreq}, 8'h00);
		if (!w)
			chk({7'h0, rvalid}, 8'h01);
		q = readdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q & m, e);
	endtask
	// Polls busy; long enough for one byte at divide by 16
	task automatic wait_idle();
		q = 8'hFF;
		for (int k = 0; k < 100 && q[1] !== 1'b0; k++)
			bus(1'b0, STATUS_OFFSET, 8'h00);
		chk(q & 8'h02, 8'h00);
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk_in);
		err_count++;
		print_verdict();
	end
	initial
	begin
		{resetn_in, rd, wr, address, writedata} = '0;
		repeat (3) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		@(posedge sys_clk_in);
		rdchk(8'h14, 8'hFF, 8'h00);
		foreach (tbl[i])
		begin
			bus(1'b1, tbl[i][23:16], tbl[i][15:8]);
			rdchk(tbl[i][23:16], 8'hFF, tbl[i][7:0]);
		end
		// Master at divide by 16: a second buffer write during the byte collides
		bus(1'b1, 8'h14, 8'h21);
		bus(1'b1, 8'h18, 8'hA5);
		bus(1'b1, 8'h18, 8'h3C);
		rdchk(8'h14, 8'hC0, 8'h80);
		wait_idle();
		rdchk(8'h14, 8'h80, 8'h80);
		bus(1'b1, 8'h14, 8'h21);
		rdchk(8'h14, 8'h80, 8'h00);
		// Second byte with the first left unread must not flag overflow in master mode
		bus(1'b1, 8'h18, 8'h11);
		wait_idle();
		rdchk(8'h14, 8'h40, 8'h00);
		rdchk(8'h18, 8'hFF, 8'hFF);
		// Slave with select, overflow interrupt unmasked
		bus(1'b1, 8'h14, 8'h24);
		bus(1'b1, 8'h24, 8'h04);
		u_partner.send(8'h96);
		rdchk(8'h1C, 8'h01, 8'h01);
		u_partner.send(8'h3C);
		rdchk(8'h14, 8'h40, 8'h40);
		chk(irq, 8'h01);
		rdchk(8'h18, 8'hFF, 8'h96);
		rdchk(8'h1C, 8'h01, 8'h00);
		rdchk(8'h20, 8'h04, 8'h04);
		chk(irq, 8'h00);
		// Done event while masked, then unmasked, then cleared by the read
		bus(1'b1, 8'h24, 8'h00);
		u_partner.send(8'h5A);
		chk(irq, 8'h00);
		bus(1'b1, 8'h24, 8'h01);
		chk(irq, 8'h01);
		rdchk(8'h20, 8'h01, 8'h01);
		chk(irq, 8'h00);
		bus(1'b1, 8'h14, 8'h00);
		chk({pins, sck_oe_n, sdo_oe_n}, 8'h03);
		print_verdict();
	end
endmodule // sync_serial_port_control_flags_tb
